// File: rtl/interval_carry_timer.sv
// Polled interval timer with read-and-reset carry flag.
//
// How it works
// - The carry flag bit 0 of the judge register mirrors the flip-flop.
// - Mode bit 3 picks internal base clock (0) or timer input pin (1).
// - Internal: low bits pick 100 ms, 5 ms, 1 ms, 125 us; zero-cross ignored.
// - External: mode bit 1 divides pin clock by 5 (0) or 6 (1).
// - External: mode bit 2 turns zero-cross detection on the pin on.
// - A window_read_instruction read of the judge register returns the flag and clears it.
// - After power-on the flag stays clear until the first read.
// - Judge register reads flag in bit 0, upper three bits zero.
// - Changing selection sets the flag only on a rising selected pulse.
`timescale 1ns/1ps
`default_nettype none
module interval_carry_timer
  import interval_timer_pkg::*;
#(
  parameter int cyc_1ms   = period_1ms_us * clock_mhz,
  parameter int cyc_5ms   = period_5ms_us * clock_mhz,
  parameter int cyc_100ms = period_100ms_us * clock_mhz
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clock_en,
  input  wire logic       clock_stop,
  input  wire logic       ce_reset,
  input  wire logic       reg_write,
  input  wire logic       reg_window_read_instruction,
  input  wire logic [6:0] reg_addr,
  input  wire logic [3:0] reg_wdata,
  input  wire logic       timer_input_pin,
  output logic      [3:0] reg_rdata,
  output logic            reg_rvalid,
  output logic      [3:0] mode_out,
  output logic            interval_carry_flag
);

  // ---------------------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------------------
  // Both register addresses are matched the same way.
  function automatic logic addr_is(input logic [6:0] addr, input logic [6:0] target);
    addr_is = addr == target;
  endfunction : addr_is

  reg_req_s req;
  assign req = '{write: reg_write, window_read_instruction: reg_window_read_instruction, addr: reg_addr, wdata: reg_wdata};

  wire mode_hit  = addr_is(req.addr, mode_select_addr);
  wire judge_hit = addr_is(req.addr, carry_judge_addr);
  wire mode_wr   = req.write && mode_hit;
  wire judge_rd  = req.window_read_instruction && judge_hit;

  mode_s mode_q;
  mode_s mode_d;
  logic  flag_q;
  logic  flag_d;
  logic  armed_q;
  logic  armed_d;
  logic  sel_q;

  // Clock stop outranks a write in the same cycle; a chip-enable reset leaves the mode alone.
  assign mode_d = clock_stop ? mode_s'(mode_reset_val)
                             : (mode_wr ? mode_s'(req.wdata) : mode_q);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= mode_s'(mode_reset_val);
    end else if (clock_en) begin
      mode_q <= mode_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Internal interval pulses
  // ---------------------------------------------------------------------------
  logic [3:0] int_pulse;

  interval_pulse_gen #(
    .cyc_125us (cycles_125us),
    .cyc_1ms   (cyc_1ms),
    .cyc_5ms   (cyc_5ms),
    .cyc_100ms (cyc_100ms)
  ) u_pulse (
    .clock       (clock),
    .rst         (rst),
    .clock_en    (clock_en),
    .pulse_level (int_pulse)
  );

  // ---------------------------------------------------------------------------
  // External clock path
  // ---------------------------------------------------------------------------
  logic       pin_q;
  logic       zx_q;
  logic [2:0] ext_cnt_q;
  logic       ext_pulse_q;

  // Zero-cross detection squares up the input by requiring two equal samples.
  wire pin_edge   = timer_input_pin != pin_q;
  wire zx_level   = (timer_input_pin == pin_q) ? pin_q : zx_q;
  wire ext_src    = mode_q.zero_cross ? zx_level : timer_input_pin;
  wire ext_src_q  = mode_q.zero_cross ? zx_q : pin_q;
  wire ext_rise   = ext_src && !ext_src_q;
  wire [2:0] ext_div = mode_q.interval[1] ? 3'(ext_div_high) : 3'(ext_div_low);
  wire ext_wrap   = ext_cnt_q == ext_div - 3'h1;
  // A divisor change can leave the count above the new end; it then runs through zero.
  wire [2:0] ext_cnt_d   = ext_wrap ? 3'h0 : ext_cnt_q + 3'h1;
  // Divided output is high for the first half of the divide period.
  wire       ext_pulse_d = ext_wrap || (ext_cnt_q < (ext_div >> 1) - 3'h1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else if (clock_en) begin
      pin_q <= timer_input_pin;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      zx_q <= 1'b0;
    end else if (clock_en) begin
      zx_q <= zx_level;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_cnt_q <= 3'h0;
    end else if (clock_en && ext_rise) begin
      ext_cnt_q <= ext_cnt_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ext_pulse_q <= 1'b0;
    end else if (clock_en && ext_rise) begin
      ext_pulse_q <= ext_pulse_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Set pulse selection and flip-flop
  // ---------------------------------------------------------------------------
  wire int_sel   = int_pulse[mode_q.interval];
  wire sel_pulse = mode_q.ext_clock ? ext_pulse_q : int_sel;

  // A rise of the selected pulse, including one caused by a reselection, sets the flag.
  wire set_evt   = sel_pulse && !sel_q && armed_q;

  assign armed_d = armed_q || judge_rd;
  // A set that meets a read wins, so the event is seen by the next read instead of lost.
  assign flag_d  = set_evt || (flag_q && !judge_rd);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q <= 1'b0;
    end else if (clock_en) begin
      sel_q <= sel_pulse;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (clock_en) begin
      armed_q <= armed_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (clock_en) begin
      flag_q <= flag_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  wire [3:0] judge_word = {3'b000, flag_q};
  wire [3:0] rd_mux     = judge_hit ? judge_word : (mode_hit ? 4'(mode_q) : 4'h0);
  wire [3:0] rdata_d    = req.window_read_instruction ? rd_mux : reg_rdata;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 4'h0;
    end else if (clock_en) begin
      reg_rdata <= rdata_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rvalid <= 1'b0;
    end else if (clock_en) begin
      reg_rvalid <= req.window_read_instruction;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_out <= 4'h0;
    end else if (clock_en) begin
      mode_out <= mode_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      interval_carry_flag <= 1'b0;
    end else if (clock_en) begin
      interval_carry_flag <= flag_q;
    end
  end

  logic unused_ok;
  assign unused_ok = ce_reset ^ pin_edge;

endmodule : interval_carry_timer
`default_nettype wire

// File: rtl/interval_pulse_gen.sv
// Free-running base pulse generator producing the interval set pulses.
`timescale 1ns/1ps
`default_nettype none
module interval_pulse_gen
  import interval_timer_pkg::*;
#(
  parameter int cyc_125us = cycles_125us,
  parameter int cyc_1ms   = period_1ms_us * clock_mhz,
  parameter int cyc_5ms   = period_5ms_us * clock_mhz,
  parameter int cyc_100ms = period_100ms_us * clock_mhz
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clock_en,
  output logic      [3:0] pulse_level
);

  logic [23:0] cnt_q [4];

  function automatic logic [23:0] limit(input int idx);
    case (idx)
      0:       limit = 24'(cyc_100ms);
      1:       limit = 24'(cyc_5ms);
      2:       limit = 24'(cyc_1ms);
      default: limit = 24'(cyc_125us);
    endcase
  endfunction : limit

  // Each square wave is high during the first half of its period.
  for (genvar i = 0; i < 4; i++) begin : g_div
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        cnt_q[i] <= 24'h00_0000;
      end else if (clock_en) begin
        cnt_q[i] <= (cnt_q[i] == limit(i) - 24'h00_0001) ? 24'h00_0000 : cnt_q[i] + 24'h00_0001;
      end
    end
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        pulse_level[i] <= 1'b0;
      end else if (clock_en) begin
        pulse_level[i] <= cnt_q[i] < (limit(i) >> 1);
      end
    end
  end

endmodule : interval_pulse_gen
`default_nettype wire

// File: rtl/interval_timer_pkg.sv
// Constants and carrier types for the interval carry timer.
package interval_timer_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [6:0] mode_select_addr = 7'h0b;
  localparam logic [6:0] carry_judge_addr = 7'h16;
  localparam logic [3:0] mode_reset_val   = 4'h0;

  // Field positions of the mode select and judge registers.
  localparam int ext_clock_bit  = 3;
  localparam int zero_cross_bit = 2;
  localparam int sel_hi_bit     = 1;
  localparam int sel_lo_bit     = 0;
  localparam int carry_flag_bit = 0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int clock_mhz      = 125;
  localparam int period_100ms_us = 100000;
  localparam int period_5ms_us   = 5000;
  localparam int period_1ms_us   = 1000;
  localparam int period_125us_us = 125;
  localparam int cycles_125us    = period_125us_us * clock_mhz;
  localparam int ext_div_low     = 5;
  localparam int ext_div_high    = 6;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       ext_clock;
    logic       zero_cross;
    logic [1:0] interval;
  } mode_s;

  typedef struct packed {
    logic       write;
    logic       window_read_instruction;
    logic [6:0] addr;
    logic [3:0] wdata;
  } reg_req_s;

endpackage : interval_timer_pkg

// File: test/interval_checker.sv
// Port checker for the interval carry timer.
`timescale 1ns/1ps
`default_nettype none
module interval_checker
  import interval_timer_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       clock_en,
  input wire logic       clock_stop,
  input wire logic       ce_reset,
  input wire logic       reg_write,
  input wire logic       reg_window_read_instruction,
  input wire logic [6:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic [3:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [3:0] mode_out,
  input wire logic       interval_carry_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic armed_q;
  wire  judge_rd = reg_window_read_instruction && clock_en && reg_addr == carry_judge_addr;
  wire  quiet    = !reg_write && !clock_stop && clock_en;
  always_ff @(posedge clock or posedge rst)
    if (rst) armed_q <= 1'b0;
    else if (judge_rd) armed_q <= 1'b1;
  sequence mode_wr_s;
    reg_write && clock_en && !clock_stop && reg_addr == mode_select_addr;
  endsequence
  window_read_instruction_answer_a: assert property ($past(clock_en) |-> reg_rvalid == $past(reg_window_read_instruction))
    else $error("read strobe wrong");
  upper_zero_a: assert property (reg_rvalid && $past(reg_addr) == carry_judge_addr
    |-> reg_rdata[3:1] == 3'h0) else $error("judge upper bits set");
  flag_mirror_a: assert property (reg_rvalid && $past(reg_addr) == carry_judge_addr
    |-> reg_rdata[0] == interval_carry_flag) else $error("judge bit differs from flag");
  flag_fall_a: assert property ($fell(interval_carry_flag)
    |-> $past(judge_rd, 2) || $past(clock_stop, 2)) else $error("flag fell without read");
  flag_armed_a: assert property (!armed_q |-> !interval_carry_flag)
    else $error("flag set before first read");
  mode_write_a: assert property (mode_wr_s ##1 clock_en |=> mode_out == $past(reg_wdata, 2))
    else $error("mode write lost");
  stop_clear_a: assert property (clock_stop && clock_en && !reg_write ##1 clock_en
    |=> mode_out == mode_reset_val) else $error("clock stop kept mode");
  ce_hold_a: assert property (ce_reset && quiet |=> ##1 $stable(mode_out))
    else $error("mode changed on chip enable reset");
endmodule : interval_checker
bind interval_carry_timer interval_checker i_checker (
  .clock               (clock),
  .rst                 (rst),
  .clock_en            (clock_en),
  .clock_stop          (clock_stop),
  .ce_reset            (ce_reset),
  .reg_write           (reg_write),
  .reg_window_read_instruction            (reg_window_read_instruction),
  .reg_addr            (reg_addr),
  .reg_wdata           (reg_wdata),
  .reg_rdata           (reg_rdata),
  .reg_rvalid          (reg_rvalid),
  .mode_out            (mode_out),
  .interval_carry_flag (interval_carry_flag)
);
`default_nettype wire

// File: test/pin_source.sv
// External clock source that drives the timer input pin.
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
  parameter int half = 4
) (
  input  wire logic clock,
  input  wire logic run,
  input  wire logic spike,
  output logic      pin
);
  int n = 0;
  // Outside a run the pin rests low, apart from the single-cycle spikes that the bench asks for.
  always @(posedge clock) begin
    n <= (!run || n == half - 1) ? 0 : n + 1;
    pin <= run ? pin ^ (n == half - 1) : spike;
  end
endmodule : pin_source
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the interval carry timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import interval_timer_pkg::*;
  typedef struct packed {logic [3:0] mode; logic [15:0] gap;} row_s;
  localparam row_s rows [9] = '{'{4'h0, 16'h0190}, '{4'h1, 16'h0064}, '{4'h2, 16'h0028},
    '{4'h3, 16'h3d09}, '{4'h6, 16'h0028}, '{4'h8, 16'h0028}, '{4'ha, 16'h0030},
    '{4'hd, 16'h0028}, '{4'he, 16'h0030}};
  logic clock = 1'b0, rst = 1'b1, clock_en = 1'b1, clock_stop = 1'b0, ce_reset = 1'b0;
  logic reg_write = 1'b0, reg_window_read_instruction = 1'b0, run = 1'b0, spike = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [3:0] reg_wdata = 4'h0;
  logic [3:0] reg_rdata, mode_out;
  logic       reg_rvalid, interval_carry_flag, timer_input_pin;
  int miscompares = 0, compares = 0, cyc = 0, t0, t1;
  always #4 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  interval_carry_timer #(
    .cyc_1ms   (40),
    .cyc_5ms   (100),
    .cyc_100ms (400)
  ) i_interval_carry_timer (
    .clock               (clock),
    .rst                 (rst),
    .clock_en            (clock_en),
    .clock_stop          (clock_stop),
    .ce_reset            (ce_reset),
    .reg_write           (reg_write),
    .reg_window_read_instruction            (reg_window_read_instruction),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .timer_input_pin     (timer_input_pin),
    .reg_rdata           (reg_rdata),
    .reg_rvalid          (reg_rvalid),
    .mode_out            (mode_out),
    .interval_carry_flag (interval_carry_flag)
  );
  pin_source #(.half(4)) i_pin_source (.clock(clock), .run(run), .spike(spike),
    .pin(timer_input_pin));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic access(logic w, logic [6:0] a, logic [3:0] d);
    reg_write <= w;
    reg_window_read_instruction <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_window_read_instruction <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : access
  // Ten one-cycle highs on the resting pin, then time for a set to reach the flag output.
  task automatic spikes;
    repeat (10) begin
      spike <= 1'b1;
      @(posedge clock);
      spike <= 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (3) @(posedge clock);
  endtask : spikes
  // Polls the flag well inside every interval, then reads and clears it.
  task automatic wait_set(output int t);
    int n = 0;
    while (interval_carry_flag !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n > 40000) begin
        check("flag set", 1'b1, 1'b0);
        wrap_up();
      end
    end
    t = cyc;
    access(1'b0, carry_judge_addr, 4'h0);
    check("judge read", 4'h1, reg_rdata);
    check("flag cleared", 1'b0, interval_carry_flag);
  endtask : wait_set
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    run <= 1'b1;
    @(posedge clock);
    check("mode reset", mode_reset_val, mode_out);
    repeat (500) @(posedge clock);
    check("disarmed", 1'b0, interval_carry_flag);
    access(1'b0, carry_judge_addr, 4'h0);
    check("first read", 4'h0, reg_rdata);
    foreach (rows[i]) begin
      access(1'b1, mode_select_addr, rows[i].mode);
      access(1'b0, mode_select_addr, 4'h0);
      check("mode", rows[i].mode, reg_rdata);
      wait_set(t0);
      wait_set(t0);
      wait_set(t1);
      check("gap", rows[i].gap, 16'(t1 - t0));
    end
    access(1'b1, carry_judge_addr, 4'hf);
    ce_reset <= 1'b1;
    @(posedge clock);
    ce_reset <= 1'b0;
    access(1'b0, mode_select_addr, 4'h0);
    check("mode hold", 4'he, reg_rdata);
    access(1'b0, 7'h05, 4'h0);
    check("unmapped", 4'h0, reg_rdata);
    clock_stop <= 1'b1;
    @(posedge clock);
    clock_stop <= 1'b0;
    repeat (2) @(posedge clock);
    check("mode stop", mode_reset_val, mode_out);
    run <= 1'b0;
    access(1'b1, mode_select_addr, 4'hd);
    access(1'b0, carry_judge_addr, 4'h0);
    spikes();
    check("spike filtered", 1'b0, interval_carry_flag);
    access(1'b1, mode_select_addr, 4'h9);
    spikes();
    check("spike counted", 1'b1, interval_carry_flag);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
